//--- logic/dpsh_pkg.sv
// Constants, carriers and delay helpers of the DP slave service handler
package dpsh_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLK_HZ_DEF = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int WD_TICK_MS = 10;
    localparam int WD_TICK_CYCLES_DEF = WD_TICK_MS * (CLK_HZ_DEF / 1000);
    // Destination service access points
    localparam logic [6:0] SAP_SET_ADDR = 7'h37;
    localparam logic [6:0] SAP_RD_INP = 7'h38;
    localparam logic [6:0] SAP_RD_OUTP = 7'h39;
    localparam logic [6:0] SAP_GLB_CTL = 7'h3a;
    localparam logic [6:0] SAP_GET_CFG = 7'h3b;
    localparam logic [6:0] SAP_DIAG = 7'h3c;
    localparam logic [6:0] SAP_SET_PRM = 7'h3d;
    localparam logic [6:0] SAP_CHK_CFG = 7'h3e;
    localparam logic [6:0] SAP_ACY_C1A = 7'h32;
    localparam logic [6:0] SAP_ACY_C1B = 7'h33;
    localparam logic [6:0] SAP_C2_INIT = 7'h31;
    localparam logic [6:0] SAP_C2_MAX = 7'h30;
    // Parameter telegram layout
    localparam logic [7:0] PRM_STAT_IDX = 8'h00;
    localparam logic [7:0] PRM_WD1_IDX = 8'h01;
    localparam logic [7:0] PRM_WD2_IDX = 8'h02;
    localparam logic [7:0] PRM_STD_LEN = 8'h07;
    localparam logic [7:0] PRM_USER_IDX = 8'h07;
    localparam int PRM_WD_ON_BIT = 3;
    localparam int USR_FAULT_HOLD_BIT = 0;
    localparam int GC_CLEAR_BIT = 1;
    // Diagnosis answer layout
    localparam logic [7:0] DIAG_LEN = 8'h06;
    localparam int DIAG_PRM_REQ_BIT = 0;
    localparam int DIAG_CFG_FAULT_BIT = 2;
    localparam int DIAG_EXT_BIT = 3;
    localparam int DIAG_FIXED_BIT = 2;
    localparam int DIAG_WD_ON_BIT = 3;
    localparam logic [7:0] DIAG_NO_MASTER = 8'hff;
    localparam logic [15:0] IDENT_CODE = 16'h0c0d; // Arbitrary value
    localparam logic [9:0] TSDR_MIN_BITS = 10'd11;
    // String interface module footprint in the cyclic image
    localparam int CP_OUT_OCTETS = 16;
    localparam int CP_IN_OCTETS = 4;

    typedef enum logic [2:0] {
        BAUD_187K5 = 3'h0, BAUD_500K = 3'h1, BAUD_1M5 = 3'h2,
        BAUD_3M = 3'h3, BAUD_6M = 3'h4, BAUD_12M = 3'h5
    } dpsh_baud_t;

    typedef enum logic [3:0] {
        K_DX = 4'h0, K_RDI = 4'h1, K_RDO = 4'h2, K_GCFG = 4'h3, K_DIAG = 4'h4,
        K_PRM = 4'h5, K_CFG = 4'h6, K_GC = 4'h7, K_ACY = 4'h8, K_INIT = 4'h9,
        K_REJ = 4'ha
    } dpsh_kind_t;

    typedef struct packed {
        logic [7:0] data;
        logic first;
        logic last;
        logic empty; // Beat carries no data octet
        logic nil;   // No service access point addressed
        logic [6:0] dsap;
    } dpsh_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } dpsh_rsp_t;

    // Baud rate in units of 100 Baud
    function automatic logic [31:0] dpsh_baud100(input dpsh_baud_t b);
        case (b)
            BAUD_187K5: return 32'd1875;
            BAUD_500K: return 32'd5000;
            BAUD_1M5: return 32'd15000;
            BAUD_3M: return 32'd30000;
            BAUD_6M: return 32'd60000;
            default: return 32'd120000;
        endcase
    endfunction

    // Longest station delay in bit times
    function automatic logic [9:0] dpsh_max_bits(input dpsh_baud_t b);
        case (b)
            BAUD_187K5: return 10'd60;
            BAUD_500K: return 10'd100;
            BAUD_1M5: return 10'd150;
            BAUD_3M: return 10'd250;
            BAUD_6M: return 10'd450;
            default: return 10'd800;
        endcase
    endfunction

    // Bit times to clock cycles; least times round up, longest round down
    function automatic logic [15:0] dpsh_tsdr_cycles(input logic [9:0] bits,
        input dpsh_baud_t b, input logic [31:0] clk_hz, input logic round_up);
        logic [63:0] num;
        logic [63:0] den;
        logic [63:0] q;
        num = 64'(bits) * 64'(clk_hz);
        den = 64'(dpsh_baud100(b)) * 64'd100;
        q = round_up ? (num + den - 64'd1) / den : num / den;
        if (q == 64'd0)
            q = 64'd1;
        if (q > 64'd65535)
            q = 64'd65535;
        return q[15:0];
    endfunction
endpackage

//--- logic/dpsh_top.sv
// DP slave service handler: service dispatch, cyclic image, parameters
// What this block does
// - Cyclic exchange without SAP carries configured outputs
// - Reply every accepted cyclic exchange with input octets
// - First input octet is node status byte
// - Four-output octet drives lower nibble only
// - String module takes 16 out, 4 in
// - Unused assigned octets stay reserved in image
// - Diagnosis request answered with current diagnostics
// - Fault reaction chosen by parameterisation
// - Terminal parameters accepted with standard parameters
// - Serve SAP 56, 57 and 59
// - Serve SAP 58, 60, 61 and 62
// - Station address change on SAP 55 refused
// - Class 1 acyclic services on SAP 50, 51
// - Class 2 acyclic SAP assigned at connect
// - Answer between 11 bits and baud limit
// - Image transfer delay far below 1 ms
`timescale 1ns/1ps
module dpsh_top
    import dpsh_pkg::*;
#(
    parameter int OUT_LEN = 20,
    parameter int IN_LEN = 6,
    parameter logic [OUT_LEN-1:0] NIBBLE_MASK = 20'h00001,
    parameter int CFG_MAX = 32,
    parameter int CLK_HZ = CLK_HZ_DEF,
    parameter int WD_TICK_CYCLES = WD_TICK_CYCLES_DEF
) (
    input wire logic clock, // System clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic rq_valid, // Request beat valid
    output logic rq_ready, // Request beat taken
    input wire dpsh_req_t rq, // Request beat
    output logic rs_valid, // Response octet valid
    input wire logic rs_ready, // Response octet taken
    output dpsh_rsp_t rs, // Response octet
    output logic ack_short, // Short acknowledge pulse
    output logic rejected, // Request refused pulse
    output logic late, // Answer missed the longest delay
    input wire dpsh_baud_t baud_sel, // Bus baud rate
    input wire logic [7:0] node_status, // Node diagnostic status bits
    input wire logic [IN_LEN-1:0][7:0] in_image, // Module input octets
    output logic [OUT_LEN-1:0][7:0] out_image, // Module output octets
    output logic [7:0] user_prm, // Terminal parameter octet
    output logic fault_active, // Watchdog fault reaction active
    output logic acy_req, // Acyclic request pulse
    output logic [6:0] acy_sap, // SAP of acyclic request
    output logic acy_class2 // Acyclic request from class 2
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1, ST_RECV = 4'h2, ST_WAIT = 4'h4, ST_SEND = 4'h8
    } dpsh_state_t;

    typedef struct packed {
        dpsh_state_t st;
        dpsh_kind_t kind;
        logic [7:0] cnt;
        logic [7:0] rlen;
        logic [7:0] ridx;
        logic [15:0] dly;
        logic sent;
        logic late_done;
        logic [OUT_LEN-1:0][7:0] stg;
        logic [OUT_LEN-1:0][7:0] outs;
        logic [CFG_MAX-1:0][7:0] cfg;
        logic [7:0] cfg_len;
        logic cfg_ok;
        logic prm_ok;
        logic [7:0] p_stat;
        logic [7:0] p_f1;
        logic [7:0] p_f2;
        logic [7:0] p_usr;
        logic [7:0] wd_f1;
        logic [7:0] wd_f2;
        logic [7:0] usr;
        logic wd_on;
        logic [31:0] tick;
        logic [15:0] wd;
        logic fault;
        logic [6:0] c2_sap;
        logic c2_on;
        logic [6:0] a_sap;
        logic a_c2;
        logic acy_p;
        logic ack_p;
        logic rej_p;
        logic late_p;
        dpsh_rsp_t [1:0] fb;
        logic wp;
        logic rp;
        logic [1:0] n;
    } dpsh_regs_t;

    dpsh_regs_t s_q;
    dpsh_regs_t s_d;
    logic [15:0] min_cyc;
    logic [15:0] max_cyc;

    // Service dispatch by destination SAP
    function automatic dpsh_kind_t dsap_kind(input dpsh_req_t r, input logic c2_on,
        input logic [6:0] c2_sap);
        if (r.nil)
            return K_DX;
        case (r.dsap)
            SAP_RD_INP: return K_RDI;
            SAP_RD_OUTP: return K_RDO;
            SAP_GET_CFG: return K_GCFG;
            SAP_GLB_CTL: return K_GC;
            SAP_DIAG: return K_DIAG;
            SAP_SET_PRM: return K_PRM;
            SAP_CHK_CFG: return K_CFG;
            SAP_SET_ADDR: return K_REJ;
            SAP_ACY_C1A, SAP_ACY_C1B: return K_ACY;
            SAP_C2_INIT: return K_INIT;
            default: return (c2_on && r.dsap == c2_sap) ? K_ACY : K_REJ;
        endcase
    endfunction

    // Station delay window for the selected baud rate
    assign min_cyc = dpsh_tsdr_cycles(TSDR_MIN_BITS, baud_sel, 32'(CLK_HZ), 1'b1);
    assign max_cyc = dpsh_tsdr_cycles(dpsh_max_bits(baud_sel), baud_sel, 32'(CLK_HZ), 1'b0);

    // Handshakes; answers are held back until the least station delay passed
    assign rq_ready = ce && (s_q.st == ST_IDLE || s_q.st == ST_RECV);
    assign rs_valid = ce && (s_q.n != 2'd0) && (s_q.dly >= min_cyc);
    assign rs = s_q.fb[s_q.rp];

    // Next state
    always_comb
    begin
        dpsh_kind_t k;
        logic [7:0] i;
        logic [7:0] cnt_n;
        logic [7:0] rl;
        logic [7:0] rb;
        logic take;
        logic tk;
        k = s_q.kind;
        i = s_q.cnt;
        cnt_n = s_q.cnt;
        rl = 8'h00;
        rb = 8'h00;
        take = rq_valid && rq_ready;
        tk = (s_q.tick == 32'(WD_TICK_CYCLES - 1));
        s_d = s_q;
        s_d.acy_p = 1'b0;
        s_d.ack_p = 1'b0;
        s_d.rej_p = 1'b0;
        s_d.late_p = 1'b0;
        if (s_q.dly != 16'hffff)
            s_d.dly = s_q.dly + 16'h0001;
        // Bus watchdog in 10 ms ticks; the fault reaction is parameterised
        s_d.tick = tk ? 32'h0 : s_q.tick + 32'h1;
        if (tk && s_q.wd_on && s_q.prm_ok && !s_q.fault)
        begin
            if (s_q.wd == 16'h0)
            begin
                s_d.fault = 1'b1;
                if (!s_q.usr[USR_FAULT_HOLD_BIT])
                    s_d.outs = '0;
            end
            else
                s_d.wd = s_q.wd - 16'h0001;
        end
        // Response octet source
        unique case (s_q.kind)
            K_DX, K_RDI: rb = (s_q.ridx == 8'h00) ? node_status
                : in_image[8'(s_q.ridx - 8'h01)];
            K_RDO: rb = s_q.outs[s_q.ridx];
            K_GCFG: rb = s_q.cfg[s_q.ridx];
            K_DIAG:
            begin
                unique case (s_q.ridx)
                    8'h00:
                    begin
                        rb[DIAG_EXT_BIT] = (node_status != 8'h00);
                        rb[DIAG_CFG_FAULT_BIT] = !s_q.cfg_ok;
                    end
                    8'h01:
                    begin
                        rb[DIAG_PRM_REQ_BIT] = !s_q.prm_ok;
                        rb[DIAG_FIXED_BIT] = 1'b1;
                        rb[DIAG_WD_ON_BIT] = s_q.wd_on;
                    end
                    8'h03: rb = DIAG_NO_MASTER;
                    8'h04: rb = IDENT_CODE[15:8];
                    8'h05: rb = IDENT_CODE[7:0];
                    default: rb = 8'h00;
                endcase
            end
            default: rb = 8'h00;
        endcase
        unique case (s_q.st)
            ST_IDLE, ST_RECV:
            begin
                if (take)
                begin
                    if (s_q.st == ST_IDLE)
                    begin
                        k = dsap_kind(rq, s_q.c2_on, s_q.c2_sap);
                        i = 8'h00;
                        s_d.a_sap = rq.dsap;
                        s_d.a_c2 = (rq.dsap != SAP_ACY_C1A) && (rq.dsap != SAP_ACY_C1B);
                    end
                    cnt_n = i;
                    // K_DX octets go to staging, K_CFG octets straight to cfg; a refused K_CFG clears cfg_ok
                    if (!rq.empty)
                    begin
                        cnt_n = i + 8'h01;
                        unique case (k)
                            K_DX: if (i < 8'(OUT_LEN)) s_d.stg[i] = rq.data;
                            K_PRM:
                            begin
                                if (i == PRM_STAT_IDX) s_d.p_stat = rq.data;
                                if (i == PRM_WD1_IDX) s_d.p_f1 = rq.data;
                                if (i == PRM_WD2_IDX) s_d.p_f2 = rq.data;
                                if (i == PRM_USER_IDX) s_d.p_usr = rq.data;
                            end
                            K_CFG: if (i < 8'(CFG_MAX)) s_d.cfg[i] = rq.data;
                            K_GC, K_INIT: if (i == 8'h00) s_d.p_stat = rq.data;
                            default: ;
                        endcase
                    end
                    s_d.kind = k;
                    s_d.cnt = cnt_n;
                    s_d.st = ST_RECV;
                    if (rq.last)
                    begin
                        // Telegram complete: commit and choose the answer
                        s_d.dly = 16'h0;
                        s_d.sent = 1'b0;
                        s_d.late_done = 1'b0;
                        s_d.ridx = 8'h00;
                        s_d.st = ST_WAIT;
                        unique case (k)
                            K_DX:
                            begin
                                if (s_q.prm_ok && s_q.cfg_ok && cnt_n == 8'(OUT_LEN))
                                begin
                                    s_d.outs = s_d.stg;
                                    s_d.fault = 1'b0;
                                    s_d.wd = s_q.wd_f1 * s_q.wd_f2;
                                    rl = 8'(IN_LEN + 1);
                                end
                                else
                                    s_d.st = ST_IDLE;
                            end
                            K_RDI: rl = 8'(IN_LEN + 1);
                            K_RDO: rl = 8'(OUT_LEN);
                            K_GCFG: rl = s_q.cfg_len;
                            K_DIAG: rl = DIAG_LEN;
                            K_PRM:
                            begin
                                if (cnt_n >= PRM_STD_LEN)
                                begin
                                    s_d.wd_f1 = s_d.p_f1;
                                    s_d.wd_f2 = s_d.p_f2;
                                    s_d.wd = s_d.p_f1 * s_d.p_f2;
                                    s_d.wd_on = s_d.p_stat[PRM_WD_ON_BIT];
                                    s_d.usr = (cnt_n > PRM_USER_IDX) ? s_d.p_usr : 8'h00;
                                    s_d.prm_ok = 1'b1;
                                    s_d.cfg_ok = 1'b0;
                                    s_d.fault = 1'b0;
                                end
                                else
                                    s_d.st = ST_IDLE;
                            end
                            K_CFG:
                            begin
                                if (cnt_n != 8'h00 && cnt_n <= 8'(CFG_MAX))
                                begin
                                    s_d.cfg_len = cnt_n;
                                    s_d.cfg_ok = 1'b1;
                                end
                                else
                                begin
                                    s_d.cfg_ok = 1'b0;
                                    s_d.st = ST_IDLE;
                                end
                            end
                            K_GC:
                            begin
                                // Broadcast control: acted on, never answered
                                if (s_d.p_stat[GC_CLEAR_BIT])
                                    s_d.outs = '0;
                                s_d.st = ST_IDLE;
                            end
                            K_INIT:
                            begin
                                if (s_d.p_stat[6:0] <= SAP_C2_MAX)
                                begin
                                    s_d.c2_sap = s_d.p_stat[6:0];
                                    s_d.c2_on = 1'b1;
                                end
                                else
                                    s_d.st = ST_IDLE;
                            end
                            K_ACY: s_d.acy_p = 1'b1;
                            default: s_d.st = ST_IDLE;
                        endcase
                        if (s_d.st == ST_IDLE && k != K_GC)
                            s_d.rej_p = 1'b1;
                        if (s_d.st == ST_WAIT && rl != 8'h00)
                            s_d.st = ST_SEND;
                        s_d.rlen = rl;
                    end
                end
            end
            ST_WAIT:
            begin
                // Short acknowledge once the least delay has passed
                if (s_q.dly >= min_cyc)
                begin
                    s_d.ack_p = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            ST_SEND:
            begin
                if (!s_q.sent && !s_q.late_done && s_q.dly >= max_cyc)
                begin
                    s_d.late_p = 1'b1;
                    s_d.late_done = 1'b1;
                end
            end
        endcase
        // Two-entry answer buffer; a stalled receiver loses no octet
        if (rs_valid && rs_ready)
        begin
            s_d.rp = ~s_q.rp;
            s_d.n = s_d.n - 2'd1;
            s_d.sent = 1'b1;
        end
        if (s_q.st == ST_SEND && s_q.n != 2'd2 && s_q.ridx < s_q.rlen)
        begin
            s_d.fb[s_q.wp] = '{data: rb, last: (s_q.ridx == s_q.rlen - 8'h01)};
            s_d.wp = ~s_q.wp;
            s_d.n = s_d.n + 2'd1;
            s_d.ridx = s_q.ridx + 8'h01;
        end
        if (s_q.st == ST_SEND && s_d.ridx == s_q.rlen && s_d.n == 2'd0)
            s_d.st = ST_IDLE;
    end

    // State register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
        end
        else if (ce)
            s_q <= s_d;
    end

    // Lower nibble only where a four-output module holds the octet
    for (genvar g = 0; g < OUT_LEN; g++)
    begin : g_out
        assign out_image[g] = NIBBLE_MASK[g] ? {4'h0, s_q.outs[g][3:0]} : s_q.outs[g];
    end

    assign ack_short = s_q.ack_p;
    assign rejected = s_q.rej_p;
    assign late = s_q.late_p;
    assign user_prm = s_q.usr;
    assign fault_active = s_q.fault;
    assign acy_req = s_q.acy_p;
    assign acy_sap = s_q.a_sap;
    assign acy_class2 = s_q.a_c2;
endmodule // dpsh_top

//--- sim/dpsh_props.sv
// Port checks of the DP slave service handler
`timescale 1ns/1ps
module dpsh_props
    import dpsh_pkg::*;
#(
    parameter int OUT_LEN = 20,
    parameter int MIN_CYC = 4,
    parameter int MAX_CYC = 266
) (
    input wire logic clock, // System clock
    input wire logic resetn, // Reset, active low
    input wire logic rq_ready, // Request beat taken
    input wire logic rs_valid, // Answer octet valid
    input wire logic rs_ready, // Answer octet taken
    input wire dpsh_rsp_t rs, // Answer octet
    input wire logic ack_short, // Short acknowledge
    input wire logic rejected, // Refusal pulse
    input wire logic late, // Missed longest delay
    input wire logic [OUT_LEN-1:0][7:0] out_image, // Output image
    input wire logic [7:0] user_prm, // Terminal parameter
    input wire logic fault_active, // Watchdog fault
    input wire logic acy_req, // Acyclic pulse
    input wire logic [6:0] acy_sap, // Acyclic SAP
    input wire logic acy_class2 // Class 2 flag
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Busy cycles since commit; idle clears it so each answer starts at zero
    always_comb
    begin
        cnt_d = rq_ready ? 16'h0000 : cnt_q + 16'h0001;
    end
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            cnt_q <= 16'h0000;
        else
            cnt_q <= cnt_d;
    end
    chk_min_delay: assert property (rs_valid |-> cnt_q >= MIN_CYC)
        else $error("answer before least station delay");
    chk_late_bound: assert property (late |-> cnt_q >= MAX_CYC)
        else $error("late flagged too early");
    chk_ack_delay: assert property (ack_short |-> rq_ready && $past(cnt_q) >= MIN_CYC)
        else $error("acknowledge timing wrong");
    chk_reject_keeps: assert property (rejected |-> $stable(out_image) && $stable(user_prm))
        else $error("refused telegram changed state");
    chk_nibble_mask: assert property (out_image[0][7:4] == 4'h0)
        else $error("upper nibble driven");
    chk_answer_hold: assert property (rs_valid && !rs_ready |=> rs_valid && $stable(rs))
        else $error("answer octet dropped");
    chk_last_idle: assert property (rs_valid && rs_ready && rs.last |-> ##[1:2] rq_ready)
        else $error("no return to idle after last octet");
    chk_acy_class: assert property (acy_req |->
        acy_class2 == !(acy_sap == SAP_ACY_C1A || acy_sap == SAP_ACY_C1B))
        else $error("acyclic class wrong");
    chk_fault_clear: assert property (fault_active && !user_prm[0] |-> out_image == '0)
        else $error("outputs kept during fault");
    cov_ack: cover property (ack_short);
    cov_rej: cover property (rejected);
    cov_late: cover property (late);
    cov_fault: cover property ($rose(fault_active));
endmodule // dpsh_props
bind dpsh_top dpsh_props #(.OUT_LEN(OUT_LEN)) dpsh_props_i (.clock(clock), .resetn(resetn),
    .rq_ready(rq_ready), .rs_valid(rs_valid), .rs_ready(rs_ready), .rs(rs),
    .ack_short(ack_short), .rejected(rejected), .late(late), .out_image(out_image),
    .user_prm(user_prm), .fault_active(fault_active), .acy_req(acy_req),
    .acy_sap(acy_sap), .acy_class2(acy_class2));

//--- sim/dpsh_master.sv
// Behavioural DP master: sends telegrams, takes answers with stalls
`timescale 1ns/1ps
module dpsh_master
    import dpsh_pkg::*;
(
    input wire logic clock, // System clock
    output logic rq_valid, // Request beat valid
    input wire logic rq_ready, // Request beat taken
    output dpsh_req_t rq, // Request beat
    input wire logic rs_valid, // Answer octet valid
    output logic rs_ready, // Answer octet taken
    input wire dpsh_rsp_t rs // Answer octet
);
    logic [7:0] got[$]; // Octets taken from the answer
    int mode = 0; // 0 prompt, 1 every other cycle, 2 hold off
    logic ph = 1'b0;
    initial
    begin
        rq_valid = 1'b0;
        rq = '0;
        rs_ready = 1'b0;
    end
    // Beat held until ready at a rising edge; released bus inverted
    task automatic send(input logic nl, input logic [6:0] sap, input logic [7:0] d[$],
        input logic emp);
        int i;
        for (i = 0; i < d.size(); i++)
        begin
            @(negedge clock);
            rq_valid = 1'b1;
            rq = '{data: d[i], first: (i == 0), last: (i == d.size() - 1), empty: emp,
                nil: nl, dsap: sap};
            do @(posedge clock); while (rq_ready !== 1'b1);
        end
        @(negedge clock);
        rq_valid = 1'b0;
        rq = ~rq;
    endtask
    // Receiver stall pattern
    always @(negedge clock)
    begin
        ph <= ~ph;
        rs_ready <= (mode == 0) || (mode == 1 && ph);
    end
    always @(posedge clock)
    begin
        if (rs_valid && rs_ready)
            got.push_back(rs.data);
    end
endmodule // dpsh_master

//--- sim/test_dp_slave_service_handler.sv
// Self-checking bench of the DP slave service handler
`timescale 1ns/1ps
module test_dp_slave_service_handler;
    import dpsh_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0, ce = 1'b1;
    logic rq_valid, rq_ready, rs_valid, rs_ready, ack_short, rejected, late;
    logic fault_active, acy_req, acy_class2, seen_ack, seen_rej;
    dpsh_req_t rq;
    dpsh_rsp_t rs;
    logic [6:0] acy_sap;
    logic [7:0] user_prm, node_status = 8'h08;
    logic [3:0][7:0] out_image;
    int miscompares = 0;
    int cmp_count = 0;
    dpsh_top #(.OUT_LEN(4), .IN_LEN(2), .NIBBLE_MASK(4'h1), .CLK_HZ(4_000_000),
        .WD_TICK_CYCLES(20)) dpsh_top_i (.clock(clock), .resetn(resetn), .ce(ce),
        .rq_valid(rq_valid), .rq_ready(rq_ready), .rq(rq), .rs_valid(rs_valid),
        .rs_ready(rs_ready), .rs(rs), .ack_short(ack_short), .rejected(rejected),
        .late(late), .baud_sel(BAUD_12M), .node_status(node_status), .in_image({8'hb2, 8'ha1}),
        .out_image(out_image), .user_prm(user_prm), .fault_active(fault_active),
        .acy_req(acy_req), .acy_sap(acy_sap), .acy_class2(acy_class2));
    dpsh_master dpsh_master_i (.clock(clock), .rq_valid(rq_valid), .rq_ready(rq_ready),
        .rq(rq), .rs_valid(rs_valid), .rs_ready(rs_ready), .rs(rs));
    initial
    begin
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One telegram; pulses gathered until idle again
    task automatic xact(input logic nl, input logic [6:0] sap, input logic [7:0] d[$],
        input logic emp);
        int k;
        dpsh_master_i.got.delete();
        seen_ack = 1'b0;
        seen_rej = 1'b0;
        dpsh_master_i.send(nl, sap, d, emp);
        for (k = 0; k < 2000; k++)
        begin
            seen_ack |= ack_short;
            seen_rej |= rejected;
            if (rq_ready === 1'b1 && k > 1)
                break;
            @(negedge clock);
        end
        chk("idle", 1, k < 2000);
    endtask
    task automatic t_setup;
        xact(0, SAP_SET_PRM, '{8'h00, 8'h01, 8'h01, 0, 0, 0, 0, 8'h5a}, 0);
        chk("prm ack", 1, seen_ack);
        chk("user prm", 8'h5a, user_prm);
        xact(0, SAP_CHK_CFG, '{8'h20}, 0);
        chk("cfg ack", 1, seen_ack);
    endtask
    task automatic t_cyclic;
        dpsh_master_i.mode = 1;
        xact(1, 7'h00, '{8'hff, 8'h01, 8'h02, 8'h03}, 0);
        dpsh_master_i.mode = 0;
        chk("dx size", 3, dpsh_master_i.got.size());
        chk("dx status", 8'h08, dpsh_master_i.got[0]);
        chk("dx inputs", 16'hb2a1, {dpsh_master_i.got[2], dpsh_master_i.got[1]});
        chk("outputs", 32'h0302010f, out_image);
        xact(1, 7'h00, '{8'h11, 8'h22, 8'h33}, 0);
        chk("short dx", 1, seen_rej);
        chk("image kept", 32'h0302010f, out_image);
    endtask
    task automatic t_refuse;
        xact(0, SAP_SET_ADDR, '{8'h09}, 0);
        chk("addr sap", 1, seen_rej);
        xact(0, 7'h05, '{8'h09}, 0);
        chk("free sap", 1, seen_rej);
    endtask
    task automatic t_reads;
        logic [6:0] sap[4] = '{SAP_RD_INP, SAP_RD_OUTP, SAP_GET_CFG, SAP_DIAG};
        int len[4] = '{3, 4, 1, 6};
        logic [7:0] b0[4] = '{8'h08, 8'hff, 8'h20, 8'h08};
        int i;
        for (i = 0; i < 4; i++)
        begin
            xact(0, sap[i], '{8'h00}, 1);
            chk("read size", len[i], dpsh_master_i.got.size());
            chk("read head", b0[i], dpsh_master_i.got[0]);
        end
    endtask
    task automatic t_acyclic;
        xact(0, SAP_ACY_C1B, '{8'h00}, 1);
        chk("acy ack", 1, seen_ack);
        chk("acy class", 0, acy_class2);
        chk("acy sap", SAP_ACY_C1B, acy_sap);
        xact(0, SAP_GLB_CTL, '{8'h02}, 0);
        chk("gc silent", 0, seen_rej);
        chk("gc clear", 0, out_image);
    endtask
    task automatic t_late;
        int k;
        dpsh_master_i.mode = 2;
        fork
            xact(0, SAP_RD_INP, '{8'h00}, 1);
            begin
                for (k = 0; k < 400 && late !== 1'b1; k++)
                    @(negedge clock);
                chk("late", 1, k > 260 && k < 400);
                dpsh_master_i.mode = 0;
            end
        join
    endtask
    task automatic t_fault;
        int k;
        xact(0, SAP_SET_PRM, '{8'h08, 8'h05, 8'h04, 0, 0, 0, 0, 8'h00}, 0);
        xact(0, SAP_CHK_CFG, '{8'h20}, 0);
        xact(1, 7'h00, '{8'h0f, 8'h44, 8'h55, 8'h66}, 0);
        repeat (300) @(negedge clock);
        chk("no fault yet", 0, fault_active);
        for (k = 0; k < 200 && fault_active !== 1'b1; k++)
            @(negedge clock);
        chk("fault", 1, fault_active);
        chk("fault outputs", 0, out_image);
    endtask
    initial
    begin
        #(25ns * 20000);
        miscompares++;
        stop_test;
    end
    initial
    begin
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        t_setup;
        t_cyclic;
        t_refuse;
        t_reads;
        t_acyclic;
        t_late;
        t_fault;
        stop_test;
    end
endmodule // test_dp_slave_service_handler
